// File: verilog/mmdia_pkg.sv
// shared constants and types for the management slave with indirect extended access
package mmdia_pkg;

  // direct register numbers on the management bus
  localparam logic [4:0]  REG_ACC_CTRL   = 5'h0D;  // mmd_access_control
  localparam logic [4:0]  REG_ADDR_DATA  = 5'h0E;  // mmd_address_or_data

  // mmd_access_control field positions
  localparam int          FUNC_HI        = 15;
  localparam int          FUNC_LO        = 14;
  localparam int          DEVSEL_HI      = 4;
  localparam int          DEVSEL_LO      = 0;

  // the single supported manageable_device_select value
  localparam logic [4:0]  MMD_DEVSEL     = 5'h1F;

  // access functions held in the function field
  localparam logic [1:0]  FUNC_ADDR      = 2'h0;   // address pointer access
  localparam logic [1:0]  FUNC_DATA      = 2'h1;   // data, pointer held
  localparam logic [1:0]  FUNC_INC_RW    = 2'h2;   // data, increment on reads and writes
  localparam logic [1:0]  FUNC_INC_WR    = 2'h3;   // data, increment on writes only

  // reset values, pointer step and standard span
  localparam logic [15:0] ACC_RESET      = 16'h0000;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [15:0] PTR_STEP       = 16'h0001;
  localparam logic [15:0] STD_SPAN       = 16'h0020;  // pointer values below this are standard regs

  // management frame opcodes and bit counts
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [5:0]  PRE_LEN        = 6'h20;  // ones needed before a start
  localparam logic [5:0]  OP_LAST        = 6'h01;
  localparam logic [5:0]  ADDR_LAST      = 6'h09;
  localparam logic [5:0]  TA_LAST        = 6'h01;
  localparam logic [5:0]  DATA_LAST      = 6'h0F;

  // memory address widths
  localparam int          STD_AW         = 5;
  localparam int          EXT_AW         = 8;

  // frame receiver states, gray along the normal path
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_OP    = 3'b011,
    S_ADDR  = 3'b010,
    S_TA    = 3'b110,
    S_DATA  = 3'b111
  } mmdia_state_t;

  // frame header as shifted in, first bit at the top
  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regad;
  } mmdia_hdr_t;

endpackage : mmdia_pkg

// File: verilog/mmdia_sync.sv
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module mmdia_sync #(
  parameter int W = 2
) (
  // clock, enable and reset
  input  wire logic         clk_i,
  input  wire logic         ce_i,
  input  wire logic         rst_i,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  genvar gi;

  // each bit passes two flops; the first is read by the second only
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else if (ce_i) begin
          meta_reg <= d_i[gi];
          sync_reg <= meta_reg;
        end
      end
      assign q_o[gi] = sync_reg;
    end
  endgenerate

endmodule : mmdia_sync

// File: verilog/mmdia_ram.sv
// small register memory with registered read data
`timescale 1ns/1ps
module mmdia_ram #(
  parameter int AW = 5
) (
  // clock, enable and reset
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  input  wire logic          rst_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [15:0]   wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [15:0]   rdata_o
);

  logic [15:0] mem_reg [0:(1<<AW)-1];
  logic [15:0] rdata_reg;

  // storage holds no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // read data comes out of a register one cycle after the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (ce_i) begin
      rdata_reg <= mem_reg[raddr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule : mmdia_ram

// File: verilog/mmdia_top.sv
// management bus slave with direct standard and indirect extended register access
`timescale 1ns/1ps
module mmdia_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock, enable and reset
  input  wire logic        clk_sys_i,
  input  wire logic        ce_i,
  input  wire logic        rst_i,
  // management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  // status
  output logic [15:0]      ext_pointer_o,
  output logic [1:0]       access_function_o,
  output logic             frame_busy_o
);

  // synchronised pins and clock edge
  logic [1:0]              sync_w;
  logic                    mdc_s_w;
  logic                    bit_w;
  logic                    mdc_d_reg;
  logic                    rise_w;

  // frame receiver state
  mmdia_pkg::mmdia_state_t state_reg;
  mmdia_pkg::mmdia_state_t state_next;
  logic [5:0]              cnt_reg;
  logic [5:0]              cnt_next;
  logic [11:0]             hdr_sh_reg;
  logic [11:0]             hdr_sh_next;
  logic [15:0]             data_sh_reg;
  logic [15:0]             data_sh_next;
  logic                    mdio_o_reg;
  logic                    mdio_o_next;
  logic                    oe_reg;
  logic                    oe_next;
  logic                    busy_reg;
  logic                    end_write_w;
  logic                    end_read_w;
  mmdia_pkg::mmdia_hdr_t   hdr_w;

  // register state
  logic [15:0]             acc_reg;
  logic [15:0]             acc_next;
  logic [15:0]             ptr_reg;
  logic [15:0]             ptr_next;
  logic [1:0]              func_reg;

  // decode wires
  logic                    is_read_w;
  logic                    is_write_w;
  logic                    match_w;
  logic                    drive_w;
  logic                    sel_acc_w;
  logic                    sel_ad_w;
  logic                    devsel_ok_w;
  logic [1:0]              func_w;
  logic                    ind_data_w;
  logic                    ptr_std_w;
  logic                    ptr_blocked_w;
  logic [15:0]             wr_data_w;
  logic [15:0]             std_rd_w;
  logic [15:0]             ext_rd_w;
  logic [15:0]             ind_value_w;
  logic [15:0]             ad_value_w;
  logic [15:0]             read_value_w;
  logic [4:0]              std_addr_w;
  logic                    std_we_w;
  logic                    ext_we_w;
  logic                    acc_we_w;
  logic                    ptr_load_w;
  logic                    ptr_inc_w;

  // pins pass two flops before use; the master owns the clock
  mmdia_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_sys_i),
    .ce_i    (ce_i),
    .rst_i   (rst_i),
    .d_i     ({mdc_i, mdio_i}),
    .q_o     (sync_w)
  );

  assign mdc_s_w = sync_w[1];
  assign bit_w   = sync_w[0];
  assign rise_w  = mdc_s_w & ~mdc_d_reg; // bits are taken on the master clock rise

  // header fields and frame qualifiers
  assign hdr_w      = mmdia_pkg::mmdia_hdr_t'(hdr_sh_reg);
  assign is_read_w  = (hdr_w.op == mmdia_pkg::OP_READ);
  assign is_write_w = (hdr_w.op == mmdia_pkg::OP_WRITE);
  assign match_w    = (hdr_w.phy == PHY_ADDR);
  assign drive_w    = is_read_w & match_w;
  assign wr_data_w  = {data_sh_reg[14:0], bit_w};

  // frame receiver and read data shifter
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    hdr_sh_next  = hdr_sh_reg;
    data_sh_next = data_sh_reg;
    mdio_o_next  = mdio_o_reg;
    oe_next      = oe_reg;
    end_write_w  = 1'b0;
    end_read_w   = 1'b0;
    if (rise_w) begin
      case (state_reg)
        mmdia_pkg::S_IDLE: begin
          oe_next = 1'b0;
          if (bit_w) begin
            if (cnt_reg != mmdia_pkg::PRE_LEN) begin
              cnt_next = cnt_reg + 6'h01;
            end
          end else if (cnt_reg == mmdia_pkg::PRE_LEN) begin
            state_next = mmdia_pkg::S_START;
            cnt_next   = 6'h00;
          end else begin
            cnt_next = 6'h00;
          end
        end
        mmdia_pkg::S_START: begin
          cnt_next   = 6'h00;
          state_next = bit_w ? mmdia_pkg::S_OP : mmdia_pkg::S_IDLE;
        end
        mmdia_pkg::S_OP: begin
          hdr_sh_next = {hdr_sh_reg[10:0], bit_w};
          cnt_next    = cnt_reg + 6'h01;
          if (cnt_reg == mmdia_pkg::OP_LAST) begin
            state_next = mmdia_pkg::S_ADDR;
            cnt_next   = 6'h00;
          end
        end
        mmdia_pkg::S_ADDR: begin
          hdr_sh_next = {hdr_sh_reg[10:0], bit_w};
          cnt_next    = cnt_reg + 6'h01;
          if (cnt_reg == mmdia_pkg::ADDR_LAST) begin
            state_next = mmdia_pkg::S_TA;
            cnt_next   = 6'h00;
          end
        end
        mmdia_pkg::S_TA: begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == 6'h00) begin
            if (!is_read_w && !is_write_w) begin
              state_next = mmdia_pkg::S_IDLE; // unknown opcode, drop the frame
              cnt_next   = 6'h00;
            end else if (drive_w) begin
              oe_next     = 1'b1; // second turnaround bit is driven low
              mdio_o_next = 1'b0;
            end
          end else if (cnt_reg == mmdia_pkg::TA_LAST) begin
            state_next = mmdia_pkg::S_DATA;
            cnt_next   = 6'h00;
            if (drive_w) begin
              mdio_o_next  = read_value_w[15];
              data_sh_next = {read_value_w[14:0], 1'b0};
            end else begin
              data_sh_next = 16'h0000;
            end
          end
        end
        mmdia_pkg::S_DATA: begin
          cnt_next = cnt_reg + 6'h01;
          if (drive_w) begin
            mdio_o_next  = data_sh_reg[15];
            data_sh_next = {data_sh_reg[14:0], 1'b0};
          end else begin
            data_sh_next = wr_data_w;
          end
          if (cnt_reg == mmdia_pkg::DATA_LAST) begin
            state_next  = mmdia_pkg::S_IDLE;
            cnt_next    = 6'h00;
            oe_next     = 1'b0;
            mdio_o_next = 1'b0;
            end_write_w = is_write_w & match_w;
            end_read_w  = drive_w;
          end
        end
        default: begin
          state_next = mmdia_pkg::S_IDLE;
          cnt_next   = 6'h00;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // frame receiver flops
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg   <= mmdia_pkg::S_IDLE;
      cnt_reg     <= 6'h00;
      hdr_sh_reg  <= 12'h000;
      data_sh_reg <= 16'h0000;
      mdio_o_reg  <= 1'b0;
      oe_reg      <= 1'b0;
      busy_reg    <= 1'b0;
      mdc_d_reg   <= 1'b0;
    end else if (ce_i) begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      hdr_sh_reg  <= hdr_sh_next;
      data_sh_reg <= data_sh_next;
      mdio_o_reg  <= mdio_o_next;
      oe_reg      <= oe_next;
      busy_reg    <= (state_next != mmdia_pkg::S_IDLE);
      mdc_d_reg   <= mdc_s_w;
    end
  end

  // target decode for the addressed register
  assign sel_acc_w     = (hdr_w.regad == mmdia_pkg::REG_ACC_CTRL);
  assign sel_ad_w      = (hdr_w.regad == mmdia_pkg::REG_ADDR_DATA);
  assign devsel_ok_w   = (acc_reg[mmdia_pkg::DEVSEL_HI:mmdia_pkg::DEVSEL_LO]
                          == mmdia_pkg::MMD_DEVSEL);
  assign func_w        = acc_reg[mmdia_pkg::FUNC_HI:mmdia_pkg::FUNC_LO];
  assign ind_data_w    = sel_ad_w & devsel_ok_w & (func_w != mmdia_pkg::FUNC_ADDR);
  assign ptr_std_w     = (ptr_reg < mmdia_pkg::STD_SPAN);
  assign ptr_blocked_w = ptr_std_w & ((ptr_reg[4:0] == mmdia_pkg::REG_ACC_CTRL)
                          | (ptr_reg[4:0] == mmdia_pkg::REG_ADDR_DATA));

  // memory addressing: data register reaches the pointed register
  assign std_addr_w = sel_ad_w ? ptr_reg[4:0] : hdr_w.regad;
  assign std_we_w   = end_write_w & ((~sel_acc_w & ~sel_ad_w)
                      | (ind_data_w & ptr_std_w & ~ptr_blocked_w));
  assign ext_we_w   = end_write_w & ind_data_w & ~ptr_std_w;

  // read value selection; ignored accesses read as zero
  assign ind_value_w  = ptr_blocked_w ? 16'h0000 : (ptr_std_w ? std_rd_w : ext_rd_w);
  assign ad_value_w   = !devsel_ok_w ? 16'h0000 :
                        (func_w == mmdia_pkg::FUNC_ADDR) ? ptr_reg : ind_value_w;
  assign read_value_w = sel_acc_w ? acc_reg : (sel_ad_w ? ad_value_w : std_rd_w);

  // control and pointer updates
  assign acc_we_w   = end_write_w & sel_acc_w; // control register only by direct write
  assign ptr_load_w = end_write_w & sel_ad_w & devsel_ok_w
                      & (func_w == mmdia_pkg::FUNC_ADDR);
  assign ptr_inc_w  = (end_write_w & ind_data_w & ((func_w == mmdia_pkg::FUNC_INC_RW)
                      | (func_w == mmdia_pkg::FUNC_INC_WR)))
                      | (end_read_w & ind_data_w & (func_w == mmdia_pkg::FUNC_INC_RW));
  assign acc_next   = acc_we_w ? wr_data_w : acc_reg;
  assign ptr_next   = ptr_load_w ? wr_data_w :
                      (ptr_inc_w ? ptr_reg + mmdia_pkg::PTR_STEP : ptr_reg); // 16-bit wrap

  // control and pointer flops
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_reg  <= mmdia_pkg::ACC_RESET;
      ptr_reg  <= mmdia_pkg::PTR_RESET;
      func_reg <= 2'h0;
    end else if (ce_i) begin
      acc_reg  <= acc_next;
      ptr_reg  <= ptr_next; // held in function 01
      func_reg <= acc_next[mmdia_pkg::FUNC_HI:mmdia_pkg::FUNC_LO];
    end
  end

  // standard registers 0 to 31
  mmdia_ram #(
    .AW (mmdia_pkg::STD_AW)
  ) u_std_ram (
    .clk_i   (clk_sys_i),
    .ce_i    (ce_i),
    .rst_i   (rst_i),
    .we_i    (std_we_w),
    .waddr_i (std_addr_w),
    .wdata_i (wr_data_w),
    .raddr_i (std_addr_w),
    .rdata_o (std_rd_w)
  );

  // extended register set, low pointer bits select the word
  mmdia_ram #(
    .AW (mmdia_pkg::EXT_AW)
  ) u_ext_ram (
    .clk_i   (clk_sys_i),
    .ce_i    (ce_i),
    .rst_i   (rst_i),
    .we_i    (ext_we_w),
    .waddr_i (ptr_reg[mmdia_pkg::EXT_AW-1:0]),
    .wdata_i (wr_data_w),
    .raddr_i (ptr_reg[mmdia_pkg::EXT_AW-1:0]),
    .rdata_o (ext_rd_w)
  );

  // outputs straight from flops
  assign mdio_o            = mdio_o_reg;
  assign mdio_oe_o         = oe_reg;
  assign ext_pointer_o     = ptr_reg;
  assign access_function_o = func_reg;
  assign frame_busy_o      = busy_reg;

endmodule : mmdia_top

// File: test/mmdia_top_assertions.sv
// concurrent checks on the management slave ports
`timescale 1ns/1ps
module mmdia_top_assertions (
  // clock and control
  input wire logic        clk_sys_i,
  input wire logic        ce_i,
  input wire logic        rst_i,
  // management pins
  input wire logic        mdc_i,
  input wire logic        mdio_i,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  // status
  input wire logic [15:0] ext_pointer_o,
  input wire logic [1:0]  access_function_o,
  input wire logic        frame_busy_o
);
  logic [15:0] ptr_cap_reg;     // pointer when a read starts driving
  logic [3:0]  since_rise_reg;  // sys cycles since the management clock rose

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // helper registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ptr_cap_reg    <= 16'h0000;
      since_rise_reg <= 4'hF;
    end else begin
      if ($rose(mdio_oe_o)) ptr_cap_reg <= ext_pointer_o;
      if ($rose(mdc_i)) since_rise_reg <= 4'h0;
      else if (since_rise_reg != 4'hF) since_rise_reg <= since_rise_reg + 4'h1;
    end
  end

  // read drive steps
  sequence s_drive_start;
    $rose(mdio_oe_o) ##0 !mdio_o;
  endsequence
  sequence s_read_done;
    $fell(mdio_oe_o) ##0 (access_function_o == 2'h2);
  endsequence

  AST_RST_VALUES: assert property (disable iff (1'b0) rst_i |=>
    (ext_pointer_o == 16'h0000) && (access_function_o == 2'h0) && !mdio_oe_o)
    else $error("outputs not at reset values");
  AST_OE_IN_FRAME: assert property ($rose(mdio_oe_o) |-> s_drive_start and frame_busy_o)
    else $error("drive started outside a frame or not low");
  AST_OE_RELEASE_LOW: assert property ($fell(mdio_oe_o) |-> !mdio_o)
    else $error("data not low at release");
  AST_BIT_AFTER_RISE: assert property (mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o)
    |-> since_rise_reg inside {[4'h1:4'h8]}) else $error("driven bit moved away from clock rise");
  AST_UPDATE_AT_END: assert property ($changed(access_function_o) || $changed(ext_pointer_o)
    |-> $past(frame_busy_o) || $past(frame_busy_o, 2) || $past(frame_busy_o, 3))
    else $error("register changed outside a frame");
  AST_FUNC01_HOLD: assert property ((access_function_o == 2'h1)
    && ($past(access_function_o) == 2'h1) |-> $stable(ext_pointer_o))
    else $error("pointer moved in plain data mode");
  AST_PTR_STEP: assert property ($changed(ext_pointer_o) && ($past(access_function_o) != 2'h0)
    |-> ext_pointer_o == $past(ext_pointer_o) + 16'h0001) else $error("pointer step not one");
  AST_INCWR_READ_HOLD: assert property ((access_function_o == 2'h3)
    && ($past(mdio_oe_o) || $past(mdio_oe_o, 2)) |-> $stable(ext_pointer_o))
    else $error("pointer moved after read in write increment mode");
  // only sound while reads in function 10 go to the data register with a valid select
  AST_INCRW_READ_STEP: assert property (s_read_done |-> ##[0:3]
    ext_pointer_o == ptr_cap_reg + 16'h0001) else $error("pointer not stepped after read");
endmodule : mmdia_top_assertions

bind mmdia_top mmdia_top_assertions u_chk (.clk_sys_i(clk_sys_i), .ce_i(ce_i), .rst_i(rst_i),
  .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .ext_pointer_o(ext_pointer_o), .access_function_o(access_function_o),
  .frame_busy_o(frame_busy_o));

// File: test/mmdia_mac_model.sv
// management bus master model making clock and data
`timescale 1ns/1ps
module mmdia_mac_model (
  // resolved data line
  input  wire logic line_i,
  // driven pins
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  // clock stands low between frames
  initial begin
    mdc_o     = 1'b0;
    mdio_o    = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // one frame with fresh preamble; reads return the data bits
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'h1, op, phy, regad, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_o    <= bits[i];
      mdio_oe_o <= !(op == mmdia_pkg::OP_READ && i < 18);  // let go for turnaround and data
      #62.5;
      if (i < 16) rd = {rd[14:0], line_i};  // taken just before our rise
      mdc_o <= 1'b1;  // only the master makes the clock
      #62.5;
      mdc_o <= 1'b0;
    end
    mdio_oe_o <= 1'b0;  // pull-up takes the line
    #62.5;
  endtask : xfer
endmodule : mmdia_mac_model

// File: test/mmdia_top_tb_top.sv
// self-checking bench for the management slave
`timescale 1ns/1ps
module mmdia_top_tb_top;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        ce     = 1'b1;
  logic        mdc, mac_d, mac_oe, dut_d, dut_oe, line, busy;
  logic [15:0] ptr, rv, v1, v2, ep;
  logic [1:0]  fn;
  logic [31:0] seed;
  int          n_mismatch = 0;
  int          checks = 0;

  // clock and line resolution with pull-up
  always #2 clk = ~clk;
  assign line = dut_oe ? dut_d : (mac_oe ? mac_d : 1'b1);

  mmdia_top DUT (.clk_sys_i(clk), .ce_i(ce), .rst_i(rst), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(dut_d), .mdio_oe_o(dut_oe), .ext_pointer_o(ptr), .access_function_o(fn),
    .frame_busy_o(busy));
  mmdia_mac_model MAC (.line_i(line), .mdc_o(mdc), .mdio_o(mac_d), .mdio_oe_o(mac_oe));

  // random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected pointer after a data access
  function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic [1:0] f,
                                          input logic is_wr);
    return (f == 2'h2 || (f == 2'h3 && is_wr)) ? p + 16'h0001 : p;
  endfunction : next_ptr

  // comparison and counting
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // direct bus accesses
  task wr(input logic [4:0] a, input logic [15:0] d);
    MAC.xfer(mmdia_pkg::OP_WRITE, 5'h01, a, d, rv);
  endtask : wr
  task rd(input logic [4:0] a, output logic [15:0] d);
    MAC.xfer(mmdia_pkg::OP_READ, 5'h01, a, 16'h0000, d);
  endtask : rd
  // pointer load then function select
  task sel(input logic [15:0] p, input logic [15:0] ctl);
    wr(5'h0D, 16'h001F);
    wr(5'h0E, p);
    wr(5'h0D, ctl);
  endtask : sel

  // verdict
  task final_report;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  // watchdog
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    final_report;
  end

  // main sequence
  initial begin
    seed = 32'he483;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset pointer", ptr, 16'h0000);
    seed = lfsr(seed);
    v1 = seed[15:0];
    wr(5'h05, v1);
    rd(5'h05, rv);
    chk("direct std", rv, v1);
    chk("idle busy", {15'h0000, busy}, 16'h0000);
    MAC.xfer(mmdia_pkg::OP_WRITE, 5'h02, 5'h05, ~v1, rv);
    rd(5'h05, rv);
    chk("foreign address", rv, v1);
    // unknown opcode frame, then a write while the clock enable is low
    MAC.xfer(2'h3, 5'h01, 5'h05, ~v1, rv);
    @(posedge clk);
    ce <= 1'b0;
    wr(5'h05, ~v1);
    @(posedge clk);
    ce <= 1'b1;
    rd(5'h05, rv);
    chk("dropped frames", rv, v1);
    sel(16'h0005, 16'h401F);
    rd(5'h0E, rv);
    chk("indirect std", rv, v1);
    chk("function", {14'h0000, fn}, {14'h0000, mmdia_pkg::FUNC_DATA});
    seed = lfsr(seed);
    v1 = seed[15:0];
    seed = lfsr(seed);
    v2 = seed[15:0];
    sel(16'h0170, 16'h401F);
    wr(5'h0E, v1);
    wr(5'h0E, v2);
    rd(5'h0E, rv);
    chk("ext overwrite", rv, v2);
    rd(5'h0E, rv);
    chk("ext reread", rv, v2);
    chk("pointer held", ptr, 16'h0170);
    wr(5'h0D, 16'h001F);
    rd(5'h0E, rv);
    chk("pointer read", rv, 16'h0170);
    wr(5'h0D, 16'h401F);
    rd(5'h0E, rv);
    chk("no reload", rv, v2);
    ep = 16'h0170;
    for (int f = 2; f <= 3; f++) begin
      wr(5'h0D, {f[1:0], 14'h001F});
      rd(5'h0E, rv);
      ep = next_ptr(ep, f[1:0], 1'b0);
      chk("inc after read", ptr, ep);
      seed = lfsr(seed);
      wr(5'h0E, seed[15:0]);
      ep = next_ptr(ep, f[1:0], 1'b1);
      chk("inc after write", ptr, ep);
    end
    wr(5'h0D, 16'h001E);
    wr(5'h0E, 16'h0000);
    chk("bad select load", ptr, ep);
    wr(5'h0D, 16'hC01E);
    rd(5'h0E, rv);
    chk("bad select read", rv, 16'h0000);
    chk("bad select pointer", ptr, ep);
    seed = lfsr(seed);
    wr(5'h0E, seed[15:0]);
    chk("bad select write", ptr, ep);
    sel(16'h000D, 16'h401F);
    seed = lfsr(seed);
    wr(5'h0E, seed[15:0]);
    rd(5'h0D, rv);
    chk("control untouched", rv, 16'h401F);
    rd(5'h0E, rv);
    chk("control via data", rv, 16'h0000);
    sel(16'hFFFF, 16'h801F);
    seed = lfsr(seed);
    wr(5'h0E, seed[15:0]);
    chk("pointer wrap", ptr, next_ptr(16'hFFFF, 2'h2, 1'b1));
    final_report;
  end
endmodule : mmdia_top_tb_top
